// ===== bench/cpdc_assertions.sv
// Purpose: port checks of the clock controller
// Assumes: one clock domain, synchronous reset
// Notes: attached by bind below
`timescale 1ns/1ps
module cpdc_assertions (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic XTAL_CLK_IN,
  input wire logic WAKE_GPIO_IN,
  input wire logic WAKE_USB_IN,
  input wire logic WAKE_HOST_IN,
  input wire logic OSC_RUN_OUT,
  input wire logic PLL_REF_OUT,
  input wire logic SYS_BUS_CLK_OUT,
  input wire logic SRAM_CLK_OUT,
  input wire logic CPU_CLK_OUT,
  input wire logic [8:0] FAST_CLK_EN_OUT,
  input wire logic CLK_READY_OUT,
  input wire logic IRQ_OUT
);
  logic wr_pwr;
  logic wake_any;
  assign wr_pwr = PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == cpdc_pkg::OFS_PWR;
  assign wake_any = WAKE_GPIO_IN || WAKE_USB_IN || WAKE_HOST_IN;
  // ------
  // checks
  // ------
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  property p_stop;
    wr_pwr && !PWDATA_IN[0] && !wake_any |=> !OSC_RUN_OUT;
  endproperty
  a_stop: assert property (p_stop) else $error("osc run not cleared");
  property p_wake;
    !OSC_RUN_OUT && wake_any |=> OSC_RUN_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_down;
    !OSC_RUN_OUT |=> !CLK_READY_OUT;
  endproperty
  a_down: assert property (p_down) else $error("ready while down");
  // a high phase in flight may finish, but no new rise while held
  property p_held;
    !CLK_READY_OUT |-> FAST_CLK_EN_OUT == 9'h0 ##1 ($past(SYS_BUS_CLK_OUT) || !SYS_BUS_CLK_OUT);
  endproperty
  a_held: assert property (p_held) else $error("clocks not held");
  property p_sram;
    SRAM_CLK_OUT == SYS_BUS_CLK_OUT;
  endproperty
  a_sram: assert property (p_sram) else $error("sram clock differs");
  property p_cpu;
    $changed(CPU_CLK_OUT) |-> CPU_CLK_OUT == $past(SYS_BUS_CLK_OUT);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu clock off bus");
  property p_ref;
    PLL_REF_OUT == (XTAL_CLK_IN && OSC_RUN_OUT);
  endproperty
  a_ref: assert property (p_ref) else $error("pll reference wrong");
  property p_irq;
    $fell(IRQ_OUT) |-> $past(wr_pwr);
  endproperty
  a_irq: assert property (p_irq) else $error("irq dropped alone");
  property p_bypass;
    wr_pwr && PWDATA_IN[1:0] == 2'h1 && OSC_RUN_OUT |-> ##[1:3] CLK_READY_OUT;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not released");
endmodule
bind cpdc_top cpdc_assertions u_chk (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .XTAL_CLK_IN(XTAL_CLK_IN),
  .WAKE_GPIO_IN(WAKE_GPIO_IN), .WAKE_USB_IN(WAKE_USB_IN), .WAKE_HOST_IN(WAKE_HOST_IN),
  .OSC_RUN_OUT(OSC_RUN_OUT), .PLL_REF_OUT(PLL_REF_OUT), .SYS_BUS_CLK_OUT(SYS_BUS_CLK_OUT),
  .SRAM_CLK_OUT(SRAM_CLK_OUT), .CPU_CLK_OUT(CPU_CLK_OUT), .FAST_CLK_EN_OUT(FAST_CLK_EN_OUT),
  .CLK_READY_OUT(CLK_READY_OUT), .IRQ_OUT(IRQ_OUT)
);

// ===== bench/cpdc_src_model.sv
// Purpose: crystal, pll and low-frequency sources
// Assumes: levels sampled at the system clock
// Notes: a stopped crystal sits low
`timescale 1ns/1ps
module cpdc_src_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic osc_run_in,
  output logic xtal_out,
  output logic pll_out,
  output logic lf_out,
  output logic tick_out
);
  logic [1:0] lf_cnt;
  initial {xtal_out, pll_out, lf_out, tick_out} = 4'h0;
  // ------
  // sources
  // ------
  // pll follows crystal, both stop with the oscillator
  always @(posedge clk_in) begin
    xtal_out <= osc_run_in && !rst_in && !xtal_out;
    pll_out <= osc_run_in && !rst_in && !pll_out;
    tick_out <= osc_run_in && !rst_in && !xtal_out;
  end
  // low-frequency crystal keeps running in power-down
  always @(posedge clk_in) begin
    lf_cnt <= rst_in ? 2'h0 : lf_cnt + 2'h1;
    lf_out <= rst_in ? 1'h0 : lf_out ^ (lf_cnt == 2'h3);
  end
endmodule

// ===== bench/cpdc_tb_top.sv
// Purpose: self-checking bench of the clock controller
// Assumes: apb master, sources from the model
// Notes: wake wait shortened by a small prescale
`timescale 1ns/1ps
module cpdc_tb_top;
  logic clk, rst, psel, penable, pwrite, pslverr, pready, err;
  logic xclk, pclk, lclk, tick, osc, rdy, irq, sbus, per, ob, op;
  logic [2:0] wake;
  logic [8:0] fen;
  logic [9:0] pen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, div1, pllc;
  logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018, 12'h020};
  logic [31:0] rv [7] = '{32'h00ffff03, 32'h83, 32'h7, 32'h0, 32'h0, 32'h0, 32'h00014035};
  logic [31:0] wv [7] = '{32'h0, 32'h1ff, 32'h3ff, 32'h0, 32'h1, 32'ha5a55a5a, 32'h12345678};
  int eb [4] = '{32, 32, 16, 8};
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nb, np;
  cpdc_top DUT (
    .CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .XTAL_CLK_IN(xclk), .PLL_CLK_IN(pclk), .LF_CLK_IN(lclk),
    .XTAL_TICK_IN(tick), .WAKE_GPIO_IN(wake[0]), .WAKE_USB_IN(wake[1]), .WAKE_HOST_IN(wake[2]),
    .OSC_RUN_OUT(osc), .PLL_REF_OUT(), .PLL_CTRL_OUT(pllc), .SYS_BUS_CLK_OUT(sbus),
    .SRAM_CLK_OUT(), .CPU_CLK_OUT(), .PERIPH_CLK_OUT(per), .FAST_CLK_EN_OUT(fen),
    .PERIPH_CLK_EN_OUT(pen), .DIV1_OUT(div1), .CLK_READY_OUT(rdy), .IRQ_OUT(irq)
  );
  cpdc_src_model u_src (.clk_in(clk), .rst_in(rst), .osc_run_in(osc), .xtal_out(xclk),
    .pll_out(pclk), .lf_out(lclk), .tick_out(tick));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // run needs about 1300 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge clk);
    wake <= w;
    @(posedge clk);
    wake <= 3'h0;
    cyc_wait(1);
  endtask
  // ------
  // tests
  // ------
  initial begin
    {rst, psel, penable, pwrite, wake, paddr, pwdata} = {1'h1, 3'h0, 3'h0, 12'h0, 32'h0};
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    cyc_wait(50);
    chk(rdy, 1'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'h0, ofs[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'h0, 12'h00c, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'h1, 12'h000, 32'h00000101);
    cyc_wait(3);
    chk(rdy, 1'h1);
    for (int i = 1; i < 7; i++) begin
      apb(1'h1, ofs[i], wv[i]);
      apb(1'h0, ofs[i], 32'h0);
      chk(rd, wv[i]);
    end
    chk(pllc, wv[6]);
    chk(div1, wv[5]);
    chk({22'h0, pen}, 32'h3ff);
    chk({23'h0, fen}, 32'h1ff);
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, 12'h010, 32'(s));
      cyc_wait(20);
      nb = 0;
      np = 0;
      repeat (128) begin
        ob = sbus;
        op = per;
        cyc_wait(1);
        nb += int'(sbus && !ob);
        np += int'(per && !op);
      end
      chk(nb inside {[eb[s] - 1:eb[s] + 1]}, 1'h1);
      chk(np inside {[eb[s] / 4 - 1:eb[s] / 4 + 1]}, 1'h1);
    end
    apb(1'h1, 12'h000, 32'hffffffff);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h00ffff07);
    apb(1'h1, 12'h000, 32'h00000106);
    cyc_wait(2);
    chk({osc, rdy}, 2'h0);
    pulse(3'h1);
    chk({osc, irq}, 2'h3);
    cyc_wait(400);
    chk(rdy, 1'h0);
    for (int i = 0; i < 300 && rdy !== 1'h1; i++) cyc_wait(1);
    chk(rdy, 1'h1);
    apb(1'h1, 12'h000, 32'h00000107);
    cyc_wait(1);
    chk(irq, 1'h1);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0000010f);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, 12'h000, 32'h00000104);
      cyc_wait(2);
      pulse(3'h1 << i);
      chk(irq, 1'h1);
      cyc_wait(2);
      chk(rdy, 1'h1);
      apb(1'h1, 12'h000, 32'h0000010d);
      cyc_wait(1);
      chk(irq, 1'h0);
    end
    apb(1'h1, 12'h000, 32'h00000100);
    cyc_wait(2);
    pulse(3'h4);
    chk(irq, 1'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h00000109);
    report_and_stop();
  end
endmodule

// ===== design/cpdc_pkg.sv
// Purpose: constants of the clock and power-down controller
// Assumes: apb register bus, 32-bit words
// Notes: offsets are byte addresses
package cpdc_pkg;
  // ---------------------------------
  // register offsets
  // ---------------------------------
  localparam logic [11:0] OFS_PWR = 12'h000;
  localparam logic [11:0] OFS_FAST = 12'h004;
  localparam logic [11:0] OFS_PERI = 12'h008;
  localparam logic [11:0] OFS_SEL = 12'h010;
  localparam logic [11:0] OFS_DIV0 = 12'h014;
  localparam logic [11:0] OFS_DIV1 = 12'h018;
  localparam logic [11:0] OFS_PLL = 12'h020;
  // ---------------------------------
  // reset values
  // ---------------------------------
  localparam logic [31:0] RST_PWR = 32'h00ffff03;
  localparam logic [31:0] RST_FAST = 32'h00000083;
  localparam logic [31:0] RST_PERI = 32'h00000007;
  localparam logic [31:0] RST_SEL = 32'h00000000;
  localparam logic [31:0] RST_DIV0 = 32'h00000000;
  localparam logic [31:0] RST_DIV1 = 32'h00000000;
  localparam logic [31:0] RST_PLL = 32'h00014035;
  // ---------------------------------
  // power_down_ctrl fields
  // ---------------------------------
  localparam int B_OSC = 0;
  localparam int B_WWEN = 1;
  localparam int B_IEN = 2;
  localparam int B_IFLG = 3;
  localparam int B_PS_LO = 8;
  localparam int B_PS_HI = 23;
  localparam int WAIT_SHIFT = 8;
  // ---------------------------------
  // other fields
  // ---------------------------------
  localparam int B_SEL_LO = 0;
  localparam int B_SEL_HI = 1;
  localparam int B_PDIV_LO = 0;
  localparam int B_PDIV_HI = 3;
  localparam int B_CPU_EN = 0;
  localparam int FAST_W = 9;
  localparam int PERI_W = 10;
  localparam logic [1:0] SRC_XTAL = 2'h0;
  localparam logic [1:0] SRC_PLL = 2'h1;
  localparam logic [1:0] SRC_PLL2 = 2'h2;
  localparam logic [1:0] SRC_LF = 2'h3;
endpackage

// ===== design/cpdc_top.sv
// Purpose: chip clock and power-down controller
// Assumes: source clocks and crystal tick are
//   synchronous samples at the 200 MHz clock
// Notes: derived clocks are toggled flops
//
// Summary of operation
// - bus clock is half of chosen source
// - bus clock also feeds sram and bus
// - processor clock is the bus clock, one cycle late
// - peripheral clock divides the bus clock
// - pll reference is the crystal
// - per-module gates, source select, divider
// - bit 0 runs or stops the oscillator
// - power-down switches the oscillator off
// - wait scale times 256 crystal cycles
// - same wait applies after reset
// - bit 1 enables or bypasses the wait
// - flag bit 3 set on restart
// - writing one clears the flag
// - bit 2 enables the wake interrupt
// - power control resets to 0x00ffff03
// - gate registers reset to documented values
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module cpdc_top (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic XTAL_CLK_IN,
  input wire logic PLL_CLK_IN,
  input wire logic LF_CLK_IN,
  input wire logic XTAL_TICK_IN,
  input wire logic WAKE_GPIO_IN,
  input wire logic WAKE_USB_IN,
  input wire logic WAKE_HOST_IN,
  output logic OSC_RUN_OUT,
  output logic PLL_REF_OUT,
  output logic [31:0] PLL_CTRL_OUT,
  output logic SYS_BUS_CLK_OUT,
  output logic SRAM_CLK_OUT,
  output logic CPU_CLK_OUT,
  output logic PERIPH_CLK_OUT,
  output logic [8:0] FAST_CLK_EN_OUT,
  output logic [9:0] PERIPH_CLK_EN_OUT,
  output logic [31:0] DIV1_OUT,
  output logic CLK_READY_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------
  // types and state
  // ---------------------------------
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_RUN = 2'b01,
    ST_DOWN = 2'b10
  } cpdc_state_e;

  cpdc_state_e state_reg;
  cpdc_state_e state_next;

  logic osc_run_reg;
  logic wake_wait_enable_reg;
  logic wake_irq_en_reg;
  logic wake_irq_flag_reg;
  logic [15:0] prescale_reg;
  logic [31:0] fast_bus_clock_gate_reg;
  logic [31:0] periph_bus_clock_gate_reg;
  logic [31:0] clock_source_choice_reg;
  logic [31:0] div0_reg;
  logic [31:0] div1_reg;
  logic [31:0] pll_reg;
  logic [31:0] prdata_reg;
  logic osc_run_d_reg;
  logic [23:0] wait_cnt_reg;
  logic src_d_reg;
  logic pll_half_reg;
  logic pll_d_reg;
  logic sys_clk_reg;
  logic sys_clk_d_reg;
  logic [3:0] pdiv_cnt_reg;
  logic periph_clk_reg;
  logic cpu_clk_reg;

  logic wr_en;
  logic rd_setup;
  logic hit;
  logic osc_rise;
  logic wake_evt;
  logic src_now;
  logic src_edge;
  logic released;
  logic sys_rise;
  logic [23:0] wait_target;
  logic [1:0] sel;

  // ---------------------------------
  // helpers
  // ---------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == cpdc_pkg::OFS_PWR) || (a == cpdc_pkg::OFS_FAST) ||
                (a == cpdc_pkg::OFS_PERI) || (a == cpdc_pkg::OFS_SEL) ||
                (a == cpdc_pkg::OFS_DIV0) || (a == cpdc_pkg::OFS_DIV1) ||
                (a == cpdc_pkg::OFS_PLL);
  endfunction

  function automatic logic wr_to(input logic [11:0] a);
    wr_to = PSEL_IN && PENABLE_IN && PWRITE_IN && (PADDR_IN == a);
  endfunction

  // ---------------------------------
  // apb slave
  // ---------------------------------
  // no wait states: read data is loaded in the setup cycle
  assign PREADY_OUT = 1'b1;
  assign hit = is_mapped(PADDR_IN);
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      prdata_reg <= 32'h00000000;
    end else if (rd_setup) begin
      case (PADDR_IN)
        cpdc_pkg::OFS_PWR: begin
          prdata_reg <= {8'h00, prescale_reg, 4'h0, wake_irq_flag_reg,
                         wake_irq_en_reg, wake_wait_enable_reg, osc_run_reg};
        end
        cpdc_pkg::OFS_FAST: begin
          prdata_reg <= fast_bus_clock_gate_reg;
        end
        cpdc_pkg::OFS_PERI: begin
          prdata_reg <= periph_bus_clock_gate_reg;
        end
        cpdc_pkg::OFS_SEL: begin
          prdata_reg <= clock_source_choice_reg;
        end
        cpdc_pkg::OFS_DIV0: begin
          prdata_reg <= div0_reg;
        end
        cpdc_pkg::OFS_DIV1: begin
          prdata_reg <= div1_reg;
        end
        cpdc_pkg::OFS_PLL: begin
          prdata_reg <= pll_reg;
        end
        default: begin
          prdata_reg <= 32'h00000000;
        end
      endcase
    end
  end

  assign PRDATA_OUT = prdata_reg;

  // ---------------------------------
  // power control register
  // ---------------------------------
  assign wake_evt = WAKE_GPIO_IN || WAKE_USB_IN || WAKE_HOST_IN;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      osc_run_reg <= cpdc_pkg::RST_PWR[cpdc_pkg::B_OSC];
      wake_wait_enable_reg <= cpdc_pkg::RST_PWR[cpdc_pkg::B_WWEN];
      wake_irq_en_reg <= cpdc_pkg::RST_PWR[cpdc_pkg::B_IEN];
      prescale_reg <= cpdc_pkg::RST_PWR[cpdc_pkg::B_PS_HI:cpdc_pkg::B_PS_LO];
    end else begin
      if (!osc_run_reg && wake_evt) begin
        osc_run_reg <= 1'b1;
      end else if (wr_to(cpdc_pkg::OFS_PWR)) begin
        osc_run_reg <= PWDATA_IN[cpdc_pkg::B_OSC];
      end
      if (wr_to(cpdc_pkg::OFS_PWR)) begin
        wake_wait_enable_reg <= PWDATA_IN[cpdc_pkg::B_WWEN];
        wake_irq_en_reg <= PWDATA_IN[cpdc_pkg::B_IEN];
        prescale_reg <= PWDATA_IN[cpdc_pkg::B_PS_HI:cpdc_pkg::B_PS_LO];
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      osc_run_d_reg <= cpdc_pkg::RST_PWR[cpdc_pkg::B_OSC];
    end else begin
      osc_run_d_reg <= osc_run_reg;
    end
  end

  assign osc_rise = osc_run_reg && !osc_run_d_reg;

  // ---------------------------------
  // wake interrupt
  // ---------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wake_irq_flag_reg <= 1'b0;
    // restart sets the flag, set beats clear
    end else if (osc_rise) begin
      wake_irq_flag_reg <= 1'b1;
    end else if (wr_to(cpdc_pkg::OFS_PWR) && PWDATA_IN[cpdc_pkg::B_IFLG]) begin
      wake_irq_flag_reg <= 1'b0;
    end
  end

  assign IRQ_OUT = wake_irq_flag_reg && wake_irq_en_reg;

  // ---------------------------------
  // gate, select, divider registers
  // ---------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      fast_bus_clock_gate_reg <= cpdc_pkg::RST_FAST;
      periph_bus_clock_gate_reg <= cpdc_pkg::RST_PERI;
      clock_source_choice_reg <= cpdc_pkg::RST_SEL;
      div0_reg <= cpdc_pkg::RST_DIV0;
      div1_reg <= cpdc_pkg::RST_DIV1;
      pll_reg <= cpdc_pkg::RST_PLL;
    end else if (wr_en) begin
      case (PADDR_IN)
        cpdc_pkg::OFS_FAST: begin
          fast_bus_clock_gate_reg <= PWDATA_IN;
        end
        cpdc_pkg::OFS_PERI: begin
          periph_bus_clock_gate_reg <= PWDATA_IN;
        end
        cpdc_pkg::OFS_SEL: begin
          clock_source_choice_reg <= PWDATA_IN;
        end
        cpdc_pkg::OFS_DIV0: begin
          div0_reg <= PWDATA_IN;
        end
        cpdc_pkg::OFS_DIV1: begin
          div1_reg <= PWDATA_IN;
        end
        cpdc_pkg::OFS_PLL: begin
          pll_reg <= PWDATA_IN;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------
  // wake-up wait sequence
  // ---------------------------------
  // target is scale times 256
  assign wait_target = {prescale_reg, 8'h00};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        if (!osc_run_reg) begin
          state_next = ST_DOWN;
        end else if (!wake_wait_enable_reg || wait_cnt_reg >= wait_target) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!osc_run_reg) begin
          state_next = ST_DOWN;
        end
      end
      ST_DOWN: begin
        if (osc_run_reg) begin
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state_reg <= ST_WAIT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wait_cnt_reg <= 24'h000000;
    end else if (state_reg != ST_WAIT) begin
      wait_cnt_reg <= 24'h000000;
    end else if (XTAL_TICK_IN && wait_cnt_reg < wait_target) begin
      wait_cnt_reg <= wait_cnt_reg + 24'h000001;
    end
  end

  assign released = (state_reg == ST_RUN);
  assign CLK_READY_OUT = released;
  assign OSC_RUN_OUT = osc_run_reg;
  assign PLL_REF_OUT = XTAL_CLK_IN && osc_run_reg;
  assign PLL_CTRL_OUT = pll_reg;
  assign DIV1_OUT = div1_reg;

  // ---------------------------------
  // source selection and halving
  // ---------------------------------
  assign sel = clock_source_choice_reg[cpdc_pkg::B_SEL_HI:cpdc_pkg::B_SEL_LO];

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      pll_d_reg <= 1'b0;
      pll_half_reg <= 1'b0;
    end else begin
      pll_d_reg <= PLL_CLK_IN;
      if (PLL_CLK_IN && !pll_d_reg) begin
        pll_half_reg <= !pll_half_reg;
      end
    end
  end

  always_comb begin
    case (sel)
      cpdc_pkg::SRC_XTAL: src_now = XTAL_CLK_IN;
      cpdc_pkg::SRC_PLL: src_now = PLL_CLK_IN;
      cpdc_pkg::SRC_PLL2: src_now = pll_half_reg;
      cpdc_pkg::SRC_LF: src_now = LF_CLK_IN;
      default: src_now = XTAL_CLK_IN;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      src_d_reg <= 1'b0;
    end else begin
      src_d_reg <= src_now;
    end
  end

  assign src_edge = src_now && !src_d_reg;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sys_clk_reg <= 1'b0;
    // hold low, finish the high phase first
    end else if (!released) begin
      if (src_edge) begin
        sys_clk_reg <= 1'b0;
      end
    // toggle per source edge halves it
    end else if (src_edge) begin
      sys_clk_reg <= !sys_clk_reg;
    end
  end

  // sram and fast bus share it
  assign SYS_BUS_CLK_OUT = sys_clk_reg;
  assign SRAM_CLK_OUT = sys_clk_reg;

  // cpu at bus rate, gating off freezes it at its current level
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cpu_clk_reg <= 1'b0;
    end else if (fast_bus_clock_gate_reg[cpdc_pkg::B_CPU_EN] || !cpu_clk_reg) begin
      cpu_clk_reg <= sys_clk_reg && fast_bus_clock_gate_reg[cpdc_pkg::B_CPU_EN];
    end
  end

  assign CPU_CLK_OUT = cpu_clk_reg;

  // ---------------------------------
  // peripheral clock divider
  // ---------------------------------
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      sys_clk_d_reg <= 1'b0;
    end else begin
      sys_clk_d_reg <= sys_clk_reg;
    end
  end

  assign sys_rise = sys_clk_reg && !sys_clk_d_reg;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      pdiv_cnt_reg <= 4'h0;
      periph_clk_reg <= 1'b0;
    end else if (!released) begin
      pdiv_cnt_reg <= 4'h0;
      periph_clk_reg <= 1'b0;
    end else if (sys_rise) begin
      if (pdiv_cnt_reg >= div0_reg[cpdc_pkg::B_PDIV_HI:cpdc_pkg::B_PDIV_LO]) begin
        pdiv_cnt_reg <= 4'h0;
        periph_clk_reg <= !periph_clk_reg;
      end else begin
        pdiv_cnt_reg <= pdiv_cnt_reg + 4'h1;
      end
    end
  end

  assign PERIPH_CLK_OUT = periph_clk_reg;

  // ---------------------------------
  // module clock enables
  // ---------------------------------
  // per-module gate held off until release
  assign FAST_CLK_EN_OUT = fast_bus_clock_gate_reg[cpdc_pkg::FAST_W-1:0] & {cpdc_pkg::FAST_W{released}};
  assign PERIPH_CLK_EN_OUT = periph_bus_clock_gate_reg[cpdc_pkg::PERI_W-1:0] & {cpdc_pkg::PERI_W{released}};

endmodule
